/* hw/lsce_defs.vh */
// Constants for the logic, skip and call execution unit
`ifndef LSCE_DEFS_VH
`define LSCE_DEFS_VH

// Instruction word layout
`define LSCE_IW_W        14
`define LSCE_PC_W        13
`define LSCE_CALL_K_W    11
// Opcode classes in word bits 13:12
`define LSCE_CLS_FILE    2'h0
`define LSCE_CLS_BIT     2'h1
`define LSCE_CLS_CALL    2'h2
`define LSCE_CLS_LIT     2'h3
// Opcode fields
`define LSCE_OP_AND_LIT  4'h9
`define LSCE_OP_AND_FILE 4'h5
`define LSCE_OP_COMP     4'h9
`define LSCE_OP_SKIP_CLR 2'h2
`define LSCE_OP_SKIP_SET 2'h3
`define LSCE_CLR_WDOG    14'h0064
// Field positions inside the instruction word
`define LSCE_F_CLS_HI    13
`define LSCE_F_CLS_LO    12
`define LSCE_F_OP_HI     11
`define LSCE_F_OP_LO     8
`define LSCE_F_BOP_LO    10
`define LSCE_F_DEST      7
`define LSCE_F_BIT_HI    9
`define LSCE_F_BIT_LO    7
// Arithmetic unit operation select
`define LSCE_ALU_AND_LIT 2'h0
`define LSCE_ALU_AND_F   2'h1
`define LSCE_ALU_COMP    2'h2
// Reset values
`define LSCE_PC_RST      13'h0000
`define LSCE_BYTE_RST    8'h00
// Field positions of the high latch used by the call target
`define LSCE_HL_HI       4
`define LSCE_HL_LO       3
// Register port map
`define LSCE_REG_HLATCH  2'h0
`define LSCE_REG_STATUS  2'h1
`define LSCE_REG_ACCUM   2'h2
`define LSCE_REG_PCLOW   2'h3
// Status read layout
`define LSCE_ST_ZERO     0
`define LSCE_ST_PD_N     3
`define LSCE_ST_TO_N     4
// File address of the pin-backed I/O port register
`define LSCE_PORT_ADDR   7'h06

`endif

/* hw/lsce_alu.v */
// Result, zero and bit-test logic of the execution unit
`timescale 1ns/1ps
`default_nettype none
`include "lsce_defs.vh"

module lsce_alu #(
    parameter DATA_W = 8
) (
    input wire [1:0] i_op,
    input wire [DATA_W-1:0] i_accum,
    input wire [DATA_W-1:0] i_file,
    input wire [DATA_W-1:0] i_literal,
    input wire [2:0] i_bit_sel,
    output reg [DATA_W-1:0] o_result,
    output wire o_zero,
    output wire o_bit_val
);

    // Result select per operation
    always @* begin
        case (i_op)
            `LSCE_ALU_AND_LIT: o_result = i_accum & i_literal;
            `LSCE_ALU_AND_F: o_result = i_accum & i_file;
            `LSCE_ALU_COMP: o_result = ~i_file;
            default: o_result = i_file;
        endcase
    end

    // Zero depends only on the result, never on the destination
    assign o_zero = (o_result == {DATA_W{1'b0}});
    // Tested bit for the skip pair
    assign o_bit_val = i_file[i_bit_sel];

endmodule // lsce_alu
`default_nettype wire

/* hw/lsce_exec.v */
// Execution unit for logic, skip, watchdog clear and call instructions
// Behaviour
// - AND literal into accumulator, zero only
// - AND file, destination bit picks target
// - Complement file, destination bit picks target
// - Skip next when tested bit clear
// - Skip next when tested bit set
// - Watchdog clear pulse, sets the timeout and power-down flags whose event is not in the same cycle, zero untouched
// - Call pushes program counter plus one first
// - Call target low, high latch upper bits
// - Call takes two cycles, flags untouched
// - Port register reads come from pins
//
// The address-and-strobe port and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "lsce_defs.vh"

module lsce_exec #(
    parameter DATA_W = 8,
    parameter FADDR_W = 7
) (
    input wire i_mclk,
    input wire i_reset,
    // Program memory, combinational read
    output wire [`LSCE_PC_W-1:0] o_prog_addr,
    input wire [`LSCE_IW_W-1:0] i_prog_word,
    // File register window
    output wire [FADDR_W-1:0] o_file_addr,
    input wire [DATA_W-1:0] i_file_rdata,
    output reg o_file_wr,
    output reg [DATA_W-1:0] o_file_wdata,
    input wire [DATA_W-1:0] i_port_pins,
    // Return stack and program counter load
    output reg o_stack_push,
    output reg [`LSCE_PC_W-1:0] o_stack_data,
    output reg o_pc_load,
    // Watchdog
    output reg o_wdog_clear,
    input wire i_timeout_event,
    input wire i_sleep_event,
    output wire o_timeout_flag_n,
    output wire o_powerdown_flag_n,
    // Register port
    input wire [1:0] i_reg_addr,
    input wire [DATA_W-1:0] i_reg_wdata,
    input wire i_reg_wr,
    input wire i_reg_rd,
    output reg [DATA_W-1:0] o_reg_rdata
);

    ////////////////////////////////////////////////////////////////////////////
    // States, one-hot
    localparam [1:0] ST_EXEC = 2'b01;
    localparam [1:0] ST_FLUSH = 2'b10;

    reg [1:0] state_q;
    reg [1:0] state_d;
    reg [`LSCE_PC_W-1:0] pc_q;
    reg [`LSCE_PC_W-1:0] pc_d;
    reg [`LSCE_PC_W-1:0] target_q;
    reg [`LSCE_PC_W-1:0] target_d;
    reg call_q;
    reg call_d;
    reg [DATA_W-1:0] accum_q;
    reg [DATA_W-1:0] accum_d;
    reg zero_q;
    reg zero_d;
    reg to_n_q;
    reg pd_n_q;
    reg [DATA_W-1:0] hlatch_q;
    reg [DATA_W-1:0] pins_meta_q;
    reg [DATA_W-1:0] pins_q;
    reg push_d;
    reg load_d;
    reg wdog_d;
    reg fwr_d;

    wire [`LSCE_PC_W-1:0] pc_inc = pc_q + {{(`LSCE_PC_W-1){1'b0}}, 1'b1};
    wire [1:0] op_class = i_prog_word[`LSCE_F_CLS_HI:`LSCE_F_CLS_LO];
    wire [3:0] op_code = i_prog_word[`LSCE_F_OP_HI:`LSCE_F_OP_LO];
    wire [1:0] op_bit = i_prog_word[`LSCE_F_OP_HI:`LSCE_F_BOP_LO];
    wire dest_file = i_prog_word[`LSCE_F_DEST];
    wire [DATA_W-1:0] literal = i_prog_word[DATA_W-1:0];
    wire [`LSCE_CALL_K_W-1:0] call_k = i_prog_word[`LSCE_CALL_K_W-1:0];
    wire in_exec = (state_q == ST_EXEC);

    wire is_and_lit = in_exec && op_class == `LSCE_CLS_LIT && op_code == `LSCE_OP_AND_LIT;
    wire is_and_file = in_exec && op_class == `LSCE_CLS_FILE && op_code == `LSCE_OP_AND_FILE;
    wire is_comp = in_exec && op_class == `LSCE_CLS_FILE && op_code == `LSCE_OP_COMP;
    wire is_skip_clr = in_exec && op_class == `LSCE_CLS_BIT && op_bit == `LSCE_OP_SKIP_CLR;
    wire is_skip_set = in_exec && op_class == `LSCE_CLS_BIT && op_bit == `LSCE_OP_SKIP_SET;
    wire is_call = in_exec && op_class == `LSCE_CLS_CALL && !i_prog_word[`LSCE_CALL_K_W];
    wire is_wdog = in_exec && i_prog_word == `LSCE_CLR_WDOG;

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchroniser; pins are asynchronous to the core clock
    always @(posedge i_mclk) begin
        if (i_reset) begin
            pins_meta_q <= `LSCE_BYTE_RST;
            pins_q <= `LSCE_BYTE_RST;
        end else begin
            pins_meta_q <= i_port_pins;
            pins_q <= pins_meta_q;
        end
    end

    // Port register reads the pins, not the output latch
    wire [FADDR_W-1:0] faddr = i_prog_word[FADDR_W-1:0];
    wire [DATA_W-1:0] file_src = (faddr == `LSCE_PORT_ADDR) ? pins_q : i_file_rdata;

    assign o_prog_addr = pc_q;
    assign o_file_addr = faddr;

    ////////////////////////////////////////////////////////////////////////////
    // Arithmetic unit
    wire [1:0] alu_op = is_and_lit ? `LSCE_ALU_AND_LIT :
                        is_and_file ? `LSCE_ALU_AND_F : `LSCE_ALU_COMP;
    wire [DATA_W-1:0] alu_result;
    wire alu_zero;
    wire bit_val;

    lsce_alu #(
        .DATA_W(DATA_W)
    ) u_alu (
        .i_op(alu_op),
        .i_accum(accum_q),
        .i_file(file_src),
        .i_literal(literal),
        .i_bit_sel(i_prog_word[`LSCE_F_BIT_HI:`LSCE_F_BIT_LO]),
        .o_result(alu_result),
        .o_zero(alu_zero),
        .o_bit_val(bit_val)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Decode and next state
    always @* begin
        state_d = ST_EXEC;
        pc_d = pc_inc;
        target_d = target_q;
        call_d = 1'b0;
        accum_d = accum_q;
        zero_d = zero_q;
        push_d = 1'b0;
        load_d = 1'b0;
        wdog_d = 1'b0;
        fwr_d = 1'b0;
        case (state_q)
            ST_EXEC: begin
                if (is_and_lit) begin
                    accum_d = alu_result;
                    zero_d = alu_zero;
                end else if (is_and_file || is_comp) begin
                    // Destination bit steers the write
                    if (dest_file) begin
                        fwr_d = 1'b1;
                    end else begin
                        accum_d = alu_result;
                    end
                    zero_d = alu_zero;
                end else if ((is_skip_clr && !bit_val) || (is_skip_set && bit_val)) begin
                    state_d = ST_FLUSH;
                end else if (is_call) begin
                    // Push first; counter holds until the second cycle
                    push_d = 1'b1;
                    pc_d = pc_q;
                    target_d = {hlatch_q[`LSCE_HL_HI:`LSCE_HL_LO], call_k};
                    call_d = 1'b1;
                    state_d = ST_FLUSH;
                end else if (is_wdog) begin
                    wdog_d = 1'b1;
                end
            end
            ST_FLUSH: begin
                // Discarded word: no write of any kind
                if (call_q) begin
                    pc_d = target_q;
                    load_d = 1'b1;
                end else begin
                    pc_d = pc_inc;
                end
            end
            default: begin
                pc_d = pc_q;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Core registers
    always @(posedge i_mclk) begin
        if (i_reset) begin
            state_q <= ST_EXEC;
            pc_q <= `LSCE_PC_RST;
            target_q <= `LSCE_PC_RST;
            call_q <= 1'b0;
            accum_q <= `LSCE_BYTE_RST;
            zero_q <= 1'b0;
            o_stack_push <= 1'b0;
            o_stack_data <= `LSCE_PC_RST;
            o_pc_load <= 1'b0;
            o_wdog_clear <= 1'b0;
            o_file_wr <= 1'b0;
            o_file_wdata <= `LSCE_BYTE_RST;
        end else begin
            state_q <= state_d;
            pc_q <= pc_d;
            target_q <= target_d;
            call_q <= call_d;
            accum_q <= accum_d;
            zero_q <= zero_d;
            o_stack_push <= push_d;
            o_stack_data <= pc_inc;
            o_pc_load <= load_d;
            o_wdog_clear <= wdog_d;
            o_file_wr <= fwr_d;
            o_file_wdata <= alu_result;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Status flags; a hardware event in the same cycle beats the clear
    always @(posedge i_mclk) begin
        if (i_reset) begin
            to_n_q <= 1'b1;
            pd_n_q <= 1'b1;
        end else begin
            if (i_timeout_event) begin
                to_n_q <= 1'b0;
            end else if (wdog_d) begin
                to_n_q <= 1'b1;
            end
            if (i_sleep_event) begin
                pd_n_q <= 1'b0;
            end else if (wdog_d) begin
                pd_n_q <= 1'b1;
            end
        end
    end

    assign o_timeout_flag_n = to_n_q;
    assign o_powerdown_flag_n = pd_n_q;

    ////////////////////////////////////////////////////////////////////////////
    // Register port, read data one cycle after the strobe
    always @(posedge i_mclk) begin
        if (i_reset) begin
            hlatch_q <= `LSCE_BYTE_RST;
            o_reg_rdata <= `LSCE_BYTE_RST;
        end else begin
            if (i_reg_wr && i_reg_addr == `LSCE_REG_HLATCH) begin
                hlatch_q <= i_reg_wdata;
            end
            o_reg_rdata <= `LSCE_BYTE_RST;
            if (i_reg_rd) begin
                if (i_reg_addr == `LSCE_REG_HLATCH) begin
                    o_reg_rdata <= hlatch_q;
                end else if (i_reg_addr == `LSCE_REG_STATUS) begin
                    o_reg_rdata[`LSCE_ST_ZERO] <= zero_q;
                    o_reg_rdata[`LSCE_ST_PD_N] <= pd_n_q;
                    o_reg_rdata[`LSCE_ST_TO_N] <= to_n_q;
                end else if (i_reg_addr == `LSCE_REG_ACCUM) begin
                    o_reg_rdata <= accum_q;
                end else begin
                    o_reg_rdata <= pc_q[DATA_W-1:0];
                end
            end
        end
    end

endmodule // lsce_exec
`default_nettype wire

/* test/lsce_prog_mem.sv */
// Program memory model feeding instruction words to the core
`timescale 1ns/1ps
`default_nettype none
module lsce_prog_mem (
    input wire logic [12:0] i_addr,
    output logic [13:0] o_word
);
    logic [13:0] mem [0:8191];
    // Same-cycle fetch, since the core has no wait state
    assign o_word = mem[i_addr];
endmodule // lsce_prog_mem
`default_nettype wire

/* test/lsce_exec_assertions.sv */
// Port-level checker for the execution unit
`timescale 1ns/1ps
`default_nettype none
`include "lsce_defs.vh"
module lsce_exec_checker (
    input wire logic i_mclk,
    input wire logic i_reset,
    input wire logic [12:0] o_prog_addr,
    input wire logic [13:0] i_prog_word,
    input wire logic o_file_wr,
    input wire logic o_stack_push,
    input wire logic [12:0] o_stack_data,
    input wire logic o_pc_load,
    input wire logic o_wdog_clear,
    input wire logic i_timeout_event,
    input wire logic i_sleep_event,
    input wire logic o_timeout_flag_n,
    input wire logic o_powerdown_flag_n,
    input wire logic [1:0] i_reg_addr,
    input wire logic i_reg_rd,
    input wire logic [7:0] o_reg_rdata
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_reset);
    ////////////////////////////////////////////////////////////
    // Call steps: push beside the old counter, then a quiet load cycle
    sequence s_push;
        o_stack_push && o_stack_data == o_prog_addr + 13'h1;
    endsequence
    sequence s_load;
        o_pc_load && !o_file_wr && !o_wdog_clear;
    endsequence
    property p_call_push;
        o_stack_push |-> s_push;
    endproperty
    property p_call_two;
        o_stack_push |=> s_load;
    endproperty
    property p_push_src;
        o_stack_push |-> ($past(i_prog_word) & 14'h3800) == 14'h2000;
    endproperty
    // Load follows the push and carries the call's low target bits
    property p_load_src;
        o_pc_load |-> $past(o_stack_push) &&
            o_prog_addr[10:0] == $past(i_prog_word[10:0], 2);
    endproperty
    // Skip flush cycles still advance the counter by one
    property p_pc_step;
        !$past(i_reset) && !o_stack_push && !o_pc_load |->
            o_prog_addr == $past(o_prog_addr) + 13'h1;
    endproperty
    property p_wdog_src;
        o_wdog_clear |-> $past(i_prog_word) == `LSCE_CLR_WDOG;
    endproperty
    // Events win over a clear, so only a clean clear is judged
    property p_wdog_flags;
        o_wdog_clear && !$past(i_timeout_event) && !$past(i_sleep_event) |->
            o_timeout_flag_n && o_powerdown_flag_n;
    endproperty
    property p_file_dest;
        o_file_wr |-> ($past(i_prog_word) & 14'h3080) == 14'h0080;
    endproperty
    property p_status_rd;
        $past(i_reg_rd) && $past(i_reg_addr) == `LSCE_REG_STATUS |->
            o_reg_rdata[4] == $past(o_timeout_flag_n) && o_reg_rdata[3] == $past(o_powerdown_flag_n);
    endproperty
    a_call_push: assert property (p_call_push) else $error("bad return address");
    a_call_two: assert property (p_call_two) else $error("bad call load cycle");
    a_push_src: assert property (p_push_src) else $error("push without call");
    a_load_src: assert property (p_load_src) else $error("load without push");
    a_pc_step: assert property (p_pc_step) else $error("counter step wrong");
    a_wdog_src: assert property (p_wdog_src) else $error("stray watchdog clear");
    a_wdog_flags: assert property (p_wdog_flags) else $error("flags not set");
    a_file_dest: assert property (p_file_dest) else $error("stray file write");
    a_status_rd: assert property (p_status_rd) else $error("status bits wrong");
endmodule // lsce_exec_checker
bind lsce_exec lsce_exec_checker u_chk (.i_mclk, .i_reset, .o_prog_addr, .i_prog_word,
    .o_file_wr, .o_stack_push, .o_stack_data, .o_pc_load, .o_wdog_clear, .i_timeout_event,
    .i_sleep_event, .o_timeout_flag_n, .o_powerdown_flag_n, .i_reg_addr, .i_reg_rd,
    .o_reg_rdata);
`default_nettype wire

/* test/lsce_exec_tb_top.sv */
// Self-checking bench for the execution unit
`timescale 1ns/1ps
`default_nettype none
`include "lsce_defs.vh"
module lsce_exec_tb_top;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic wr = 1'b0, rd = 1'b0, tmo = 1'b0, slp = 1'b0;
    logic [1:0] ra = 2'h0;
    logic [7:0] rwd = 8'h00, pins = 8'h00, fwd, rdat;
    logic [7:0] fmem [0:127];
    logic [6:0] fa_q = 7'h00, fa;
    logic [12:0] pc, sdat;
    logic [13:0] word;
    logic fwr, push, pld, wdc, to_n, pd_n;
    int n_errors = 0;
    int n_checks = 0;
    always #5 clk = ~clk;
    lsce_prog_mem u_mem (.i_addr(pc), .o_word(word));
    lsce_exec u_dut (.i_mclk(clk), .i_reset(rst), .o_prog_addr(pc), .i_prog_word(word),
        .o_file_addr(fa), .i_file_rdata(fmem[fa]), .o_file_wr(fwr), .o_file_wdata(fwd),
        .i_port_pins(pins), .o_stack_push(push), .o_stack_data(sdat), .o_pc_load(pld),
        .o_wdog_clear(wdc), .i_timeout_event(tmo), .i_sleep_event(slp),
        .o_timeout_flag_n(to_n), .o_powerdown_flag_n(pd_n), .i_reg_addr(ra),
        .i_reg_wdata(rwd), .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdat));
    // Write-back lands at the previous cycle's file address
    always @(posedge clk) begin
        fa_q <= fa;
        if (fwr) fmem[fa_q] <= fwd;
    end
    ////////////////////////////////////////////////////////////
    // Shared helpers
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish;
        if (n_errors == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // Load under reset and off the rising edge, so no fetch races the load
    task automatic prog_clr;
        rst <= 1'b1;
        @(negedge clk);
        for (int i = 0; i < 8192; i++) u_mem.mem[i] = 14'h0000;
        for (int i = 0; i < 128; i++) fmem[i] = 8'h00;
    endtask
    task automatic start;
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
    endtask
    task automatic wait_pc(input logic [12:0] p);
        for (int i = 0; i < 40; i++) begin
            @(posedge clk);
            #1;
            if (pc === p) return;
        end
        n_errors++;
        tally_and_finish;
    endtask
    task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        ra <= a;
        rwd <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [1:0] a, input logic [7:0] exp);
        @(posedge clk);
        rd <= 1'b1;
        ra <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(rdat, exp);
    endtask
    ////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_logic;
        prog_clr;
        fmem[7'h20] = 8'h0f;
        fmem[7'h21] = 8'h5a;
        fmem[7'h22] = 8'hcf;
        fmem[7'h23] = 8'hf0;
        u_mem.mem[0] = {`LSCE_CLS_FILE, `LSCE_OP_COMP, 1'b0, 7'h20};
        u_mem.mem[1] = {`LSCE_CLS_LIT, `LSCE_OP_AND_LIT, 8'h3c};
        u_mem.mem[2] = {`LSCE_CLS_FILE, `LSCE_OP_AND_FILE, 1'b1, 7'h21};
        u_mem.mem[3] = {`LSCE_CLS_FILE, `LSCE_OP_AND_FILE, 1'b0, 7'h22};
        u_mem.mem[4] = {`LSCE_CLS_FILE, `LSCE_OP_COMP, 1'b1, 7'h23};
        start;
        repeat (8) @(posedge clk);
        chk(fmem[7'h21], 8'h10);
        chk(fmem[7'h22], 8'hcf);
        chk(fmem[7'h23], 8'h0f);
        rd_chk(`LSCE_REG_ACCUM, 8'h00);
        rd_chk(`LSCE_REG_STATUS, 8'h18);
    endtask
    task automatic t_pins;
        prog_clr;
        pins <= 8'ha5;
        u_mem.mem[4] = {`LSCE_CLS_FILE, `LSCE_OP_COMP, 1'b0, `LSCE_PORT_ADDR};
        start;
        repeat (6) @(posedge clk);
        wr_reg(`LSCE_REG_ACCUM, 8'h33);
        rd_chk(`LSCE_REG_ACCUM, 8'h5a);
        rd_chk(`LSCE_REG_PCLOW, 8'h0b);
    endtask
    task automatic t_skip;
        logic [7:0] fv;
        fv = 8'h5a;
        for (int op = 2; op < 4; op++) begin
            for (int b = 0; b < 8; b++) begin
                prog_clr;
                fmem[7'h30] = fv;
                u_mem.mem[0] = {`LSCE_CLS_BIT, op[1:0], b[2:0], 7'h30};
                u_mem.mem[1] = {`LSCE_CLS_FILE, `LSCE_OP_COMP, 1'b1, 7'h31};
                start;
                repeat (6) @(posedge clk);
                chk(fmem[7'h31], ((op == 3) ^ fv[b]) ? 8'hff : 8'h00);
            end
        end
    endtask
    task automatic t_call;
        prog_clr;
        u_mem.mem[8] = {`LSCE_CLS_CALL, 1'b0, 11'h7ff};
        start;
        wr_reg(`LSCE_REG_HLATCH, 8'h10);
        wait_pc(13'h8);
        @(posedge clk);
        #1;
        chk({push, pc, sdat}, {1'b1, 13'h8, 13'h9});
        @(posedge clk);
        #1;
        chk({pld, pc}, {1'b1, 13'h17ff});
        rd_chk(`LSCE_REG_HLATCH, 8'h10);
    endtask
    task automatic t_wdog;
        prog_clr;
        u_mem.mem[6] = `LSCE_CLR_WDOG;
        start;
        tmo <= 1'b1;
        slp <= 1'b1;
        @(posedge clk);
        tmo <= 1'b0;
        slp <= 1'b0;
        wait_pc(13'h6);
        chk({to_n, pd_n}, 2'b00);
        @(posedge clk);
        #1;
        chk({wdc, to_n, pd_n}, 3'b111);
        rd_chk(`LSCE_REG_STATUS, 8'h18);
    endtask
    // Main sequence
    initial begin
        t_logic;
        t_pins;
        t_skip;
        t_call;
        t_wdog;
        tally_and_finish;
    end
endmodule // lsce_exec_tb_top
`default_nettype wire
